//--- reset_cause_and_register_init.v
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "reset_init_defs.vh"

// How it works
// [R1] Undefined registers: random at power-on, otherwise kept.
// [R2] Watchdog wake-up keeps most registers intact.
// [R3] Defined registers load value for reset category.
// [R4] Power-on: PC zero, flags set per table.
// [R5] Reset instruction clears RI; brown-out sets three.
// [R6] Pin reset flag edits depend on power mode.
// [R7] Running watchdog timeout clears timeout flag, restarts.
// [R8] Sleeping watchdog timeout clears two flags, PC+2.
// [R9] Enabled stack errors set flag and restart.
// [R10] Disabled stack underflow only sets its flag.
// [R11] Interrupt wake clears PD, continues or vectors.
// [R12] Software brown-out enable reset value rule.
// [R13] Return-top cleared on resets; push on vectored interrupt wake.
// [R14] PC latches and table registers cleared on resets.
// [R15] Product, working, pointers kept; bank cleared.
// [R16] Interrupt controls load fixed values on power-on; control A keeps bit 0 on other resets.
// [R17] Brown-out flag cleared on brown-out or power-on.
// [R18] Software brown-out enable reads zero unless configured.
// [R19] All reset defaults applied in one cycle.

module reset_cause_and_register_init (
	// Clock and synchronous power-on reset.
	input  wire        core_clk,
	input  wire        resetn,
	// Reset and wake-up event pulses.
	input  wire        brownout_evt,
	input  wire        external_reset_pin_evt,
	input  wire        watchdog_evt,
	input  wire        reset_instr_evt,
	input  wire        stack_full_evt,
	input  wire        stack_underflow_evt,
	input  wire        int_wake_evt,
	// Core conditions sampled with the events.
	input  wire [1:0]  power_mode,
	input  wire        stack_overflow_reset_enable,
	input  wire [1:0]  brownout_config,
	input  wire [20:0] current_pc,
	input  wire [7:0]  wake_flags,
	// Register port.
	input  wire [4:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata_r,
	// Core control outputs.
	output reg  [20:0] program_counter_r,
	output reg         pc_load_r,
	output reg         brownout_active_r,
	output reg         irq_r
);

	// Core register storage, addressed by index.
	reg  [7:0]  core_r [0:22];
	reg  [7:0]  ev_status_r;
	reg  [7:0]  ev_mask_r;
	reg  [7:0]  ev_status_nxt;
	reg  [7:0]  rdata_nxt;
	reg  [7:0]  push_ptr_nxt;
	integer     i;

	wire [2:0]  cat;
	wire [7:0]  rc_set;
	wire [7:0]  rc_clr;
	wire [7:0]  stk_set;
	wire [7:0]  reset_control_status;
	wire [7:0]  reset_control_status_evt;
	wire [7:0]  stk;
	wire [7:0]  ev_vec;
	wire [20:0] pc_step;
	wire [20:0] vec_pc;
	wire        sw_bor_mode;
	wire        sbo_kept;
	wire        gie_any;
	wire        wr_core;
	wire        is_reset;

	// Implemented bits of each register, shared by write and read.
	function [7:0] reg_mask;
		input [4:0] idx;
		begin
			case (idx)
				`IDX_RESET_STATUS:  reg_mask = `RESET_CONTROL_STATUS_SW_MASK;
				`IDX_STACK_INDEX:   reg_mask = `STK_RD_MASK;
				`IDX_RET_UPPER:     reg_mask = `MASK_5BIT;
				`IDX_PCLATCH_UPPER: reg_mask = `MASK_5BIT;
				`IDX_TBL_UPPER:     reg_mask = `MASK_6BIT;
				`IDX_IND0_HIGH:     reg_mask = `MASK_4BIT;
				`IDX_IND1_HIGH:     reg_mask = `MASK_4BIT;
				`IDX_BANK_SELECT:   reg_mask = `MASK_4BIT;
				default:            reg_mask = 8'hFF;
			endcase
		end
	endfunction

	// Registers that every reset clears; wake-ups rewrite only the low PC byte and the return registers.
	function reg_clears;
		input [4:0] idx;
		begin
			case (idx)
				`IDX_RET_UPPER, `IDX_RET_HIGH, `IDX_RET_LOW,
				`IDX_PCLATCH_UPPER, `IDX_PCLATCH_HIGH, `IDX_PC_LOW,
				`IDX_TBL_UPPER, `IDX_TBL_HIGH, `IDX_TBL_LOW,
				`IDX_TBL_LATCH, `IDX_BANK_SELECT: reg_clears = 1'b1;
				default: reg_clears = 1'b0;
			endcase
		end
	endfunction

	// Event priority and flag edits.
	reset_event_decoder u_decoder (
		.brownout_evt                (brownout_evt),
		.external_reset_pin_evt      (external_reset_pin_evt),
		.watchdog_evt                (watchdog_evt),
		.reset_instr_evt             (reset_instr_evt),
		.stack_full_evt              (stack_full_evt),
		.stack_underflow_evt         (stack_underflow_evt),
		.int_wake_evt                (int_wake_evt),
		.power_mode                  (power_mode),
		.stack_overflow_reset_enable (stack_overflow_reset_enable),
		.cat                         (cat),
		.rc_set                      (rc_set),
		.rc_clr                      (rc_clr),
		.stk_set                     (stk_set)
	);

	// Shorthands for the status registers and derived conditions.
	assign reset_control_status = core_r[`IDX_RESET_STATUS];
	assign stk = core_r[`IDX_STACK_INDEX];
	assign reset_control_status_evt = (reset_control_status & ~rc_clr) | rc_set;
	assign pc_step = current_pc + `PC_STEP;
	// Vector chosen by the high-priority enable; only its low byte is stored.
	assign vec_pc = core_r[`IDX_INT_CTRL_A][`GIE_HIGH_BIT] ?
		`VEC_HIGH : `VEC_LOW;
	assign sw_bor_mode = (brownout_config == `BOR_CFG_SW);
	assign sbo_kept = sw_bor_mode & ((reset_control_status & `RCM_SBO) != 8'h00);
	assign gie_any = core_r[`IDX_INT_CTRL_A][`GIE_HIGH_BIT] |
		core_r[`IDX_INT_CTRL_A][`GIE_LOW_BIT];
	assign wr_core = reg_wr & (reg_addr < `NUM_CORE);
	assign is_reset = (cat == `CAT_BOR) | (cat == `CAT_RESET);
	assign ev_vec = {1'b0, int_wake_evt, stack_underflow_evt,
		stack_full_evt, reset_instr_evt, watchdog_evt,
		external_reset_pin_evt, brownout_evt};

	// Stack index after a push by an interrupt wake-up.
	always @* begin
		push_ptr_nxt = stk;
		push_ptr_nxt[4:0] = stk[4:0] + 5'h01;
		if (stk[4:0] == 5'h1F) begin
			push_ptr_nxt = push_ptr_nxt | `STK_FULL_MASK;
		end
	end

	// Core registers: power-on load, software writes, event loads.
	always @(posedge core_clk) begin
		if (!resetn) begin
			// Product, working and pointer registers stay unloaded.
			for (i = 0; i < 23; i = i + 1) begin
				if (reg_clears(i[4:0])) begin
					core_r[i] <= 8'h00; // see [R1] [R3] [R14]
				end
			end
			core_r[`IDX_RESET_STATUS] <= `RESET_CONTROL_STATUS_POR_VAL; // see [R4] [R12]
			core_r[`IDX_STACK_INDEX] <= 8'h00; // see [R4]
			core_r[`IDX_INT_CTRL_A] <= 8'h00; // see [R16]
			core_r[`IDX_INT_CTRL_B] <= `INTB_RST_VAL;
			core_r[`IDX_INT_CTRL_C] <= `INTC_RST_VAL;
		end else begin
			// Software writes land first; events below override them.
			if (wr_core) begin
				if (reg_addr == `IDX_RESET_STATUS) begin
					core_r[reg_addr] <= (reset_control_status & ~`RESET_CONTROL_STATUS_SW_MASK) |
						(reg_wdata & `RESET_CONTROL_STATUS_SW_MASK);
				end else begin
					core_r[reg_addr] <= reg_wdata & reg_mask(reg_addr);
				end
			end
			case (cat)
				`CAT_BOR, `CAT_RESET: begin
					// Every defined register loads in this one edge.
					for (i = 0; i < 23; i = i + 1) begin
						if (reg_clears(i[4:0])) begin
							core_r[i] <= 8'h00; // see [R3] [R13] [R15] [R19]
						end
					end
					if (sbo_kept) begin
						core_r[`IDX_RESET_STATUS] <= reset_control_status_evt; // see [R12]
					end else begin
						core_r[`IDX_RESET_STATUS] <= reset_control_status_evt & ~`RCM_SBO;
					end
					core_r[`IDX_STACK_INDEX] <= (stk | stk_set) &
						~`STK_PTR_MASK; // see [R13] [R9]
					core_r[`IDX_INT_CTRL_A] <= core_r[`IDX_INT_CTRL_A] &
						`INTA_RST_MASK; // see [R16]
					core_r[`IDX_INT_CTRL_B] <= `INTB_RST_VAL;
					core_r[`IDX_INT_CTRL_C] <= `INTC_RST_VAL;
				end
				`CAT_WAKE_WDT: begin
					// Resumption: only the flags and the low PC byte move.
					core_r[`IDX_RESET_STATUS] <= reset_control_status_evt; // see [R2] [R8]
					core_r[`IDX_PC_LOW] <= pc_step[7:0]; // see [R14]
				end
				`CAT_WAKE_INT: begin
					core_r[`IDX_RESET_STATUS] <= reset_control_status_evt; // see [R11]
					core_r[`IDX_INT_CTRL_A] <= core_r[`IDX_INT_CTRL_A] |
						wake_flags; // see [R16]
					if (gie_any) begin
						// Vectoring pushes the return address.
						core_r[`IDX_RET_UPPER] <= {3'h0, pc_step[20:16]}; // see [R13]
						core_r[`IDX_RET_HIGH] <= pc_step[15:8];
						core_r[`IDX_RET_LOW] <= pc_step[7:0];
						core_r[`IDX_STACK_INDEX] <= push_ptr_nxt;
						core_r[`IDX_PC_LOW] <= vec_pc[7:0]; // see [R11]
					end else begin
						core_r[`IDX_PC_LOW] <= pc_step[7:0]; // see [R14]
					end
				end
				`CAT_FLAG: begin
					// Stack error with no reset: flag only.
					core_r[`IDX_STACK_INDEX] <= stk | stk_set; // see [R10]
				end
				default: begin
					core_r[`IDX_BANK_SELECT] <= wr_core &&
						reg_addr == `IDX_BANK_SELECT ?
						(reg_wdata & `MASK_4BIT) :
						core_r[`IDX_BANK_SELECT];
				end
			endcase
		end
	end

	// Program counter load that goes with each category.
	always @(posedge core_clk) begin
		if (!resetn) begin
			program_counter_r <= `RESET_PC; // see [R4]
			pc_load_r <= 1'b0;
		end else begin
			pc_load_r <= (cat != `CAT_NONE) & (cat != `CAT_FLAG);
			case (cat)
				`CAT_BOR, `CAT_RESET: begin
					program_counter_r <= `RESET_PC; // see [R5] [R7] [R9]
				end
				`CAT_WAKE_WDT: begin
					program_counter_r <= pc_step; // see [R8]
				end
				`CAT_WAKE_INT: begin
					if (!gie_any) begin
						program_counter_r <= pc_step; // see [R11]
					end else if (core_r[`IDX_INT_CTRL_A][`GIE_HIGH_BIT]) begin
						program_counter_r <= `VEC_HIGH;
					end else begin
						program_counter_r <= `VEC_LOW;
					end
				end
				default: begin
					program_counter_r <= program_counter_r;
				end
			endcase
		end
	end

	// Sticky event status; a new event beats a same-cycle clear.
	always @* begin
		ev_status_nxt = ev_status_r;
		if (reg_wr && reg_addr == `IDX_EVT_STATUS) begin
			ev_status_nxt = ev_status_nxt & ~reg_wdata;
		end
		ev_status_nxt = ev_status_nxt | ev_vec;
	end

	// Event status, mask and the level interrupt.
	always @(posedge core_clk) begin
		if (!resetn) begin
			ev_status_r <= 8'h00;
			ev_mask_r <= 8'h00;
			irq_r <= 1'b0;
		end else begin
			ev_status_r <= ev_status_nxt;
			if (reg_wr && reg_addr == `IDX_EVT_MASK) begin
				ev_mask_r <= reg_wdata & 8'h7F;
				irq_r <= (ev_status_nxt & reg_wdata & 8'h7F) != 8'h00;
			end else begin
				irq_r <= (ev_status_nxt & ev_mask_r) != 8'h00;
			end
		end
	end

	// Brown-out detector enable seen by the supervisory circuit.
	always @(posedge core_clk) begin
		if (!resetn) begin
			brownout_active_r <= 1'b0;
		end else begin
			case (brownout_config)
				`BOR_CFG_OFF: brownout_active_r <= 1'b0;
				`BOR_CFG_SW: brownout_active_r <= (reset_control_status & `RCM_SBO) != 8'h00;
				`BOR_CFG_HW_NOSLEEP: begin
					brownout_active_r <= power_mode != `MODE_SLEEP;
				end
				default: brownout_active_r <= 1'b1;
			endcase
		end
	end

	// Read data selection; the enable bit reads zero outside mode 01.
	always @* begin
		rdata_nxt = 8'h00;
		if (reg_addr == `IDX_RESET_STATUS) begin
			rdata_nxt = sw_bor_mode ? reset_control_status : (reset_control_status & ~`RCM_SBO); // see [R18]
		end else if (reg_addr < `NUM_CORE) begin
			rdata_nxt = core_r[reg_addr] & reg_mask(reg_addr);
		end else if (reg_addr == `IDX_EVT_STATUS) begin
			rdata_nxt = ev_status_r;
		end else if (reg_addr == `IDX_EVT_MASK) begin
			rdata_nxt = ev_mask_r;
		end
	end

	// Read data stands in the cycle after the strobe only.
	always @(posedge core_clk) begin
		if (!resetn) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata_r <= rdata_nxt;
		end else begin
			reg_rdata_r <= 8'h00;
		end
	end

endmodule

//--- reset_event_decoder.v
`timescale 1ns/1ps
`include "reset_init_defs.vh"

module reset_event_decoder (
	// Event pulses.
	input  wire       brownout_evt,
	input  wire       external_reset_pin_evt,
	input  wire       watchdog_evt,
	input  wire       reset_instr_evt,
	input  wire       stack_full_evt,
	input  wire       stack_underflow_evt,
	input  wire       int_wake_evt,
	// Conditions.
	input  wire [1:0] power_mode,
	input  wire       stack_overflow_reset_enable,
	// Decoded result.
	output reg  [2:0] cat,
	output reg  [7:0] rc_set,
	output reg  [7:0] rc_clr,
	output reg  [7:0] stk_set
);

	wire low_power;

	// Idle and sleep count as stopped-core modes.
	assign low_power = (power_mode == `MODE_IDLE) |
		(power_mode == `MODE_SLEEP);

	// Picks the highest-priority event and its flag edits.
	always @* begin
		cat = `CAT_NONE;
		rc_set = 8'h00;
		rc_clr = 8'h00;
		stk_set = 8'h00;
		if (brownout_evt) begin
			cat = `CAT_BOR;
			rc_set = `RCM_RI | `RCM_TO | `RCM_PD; // see [R5]
			rc_clr = `RCM_BOR; // see [R17]
		end else if (external_reset_pin_evt) begin
			cat = `CAT_RESET;
			case (power_mode)
				`MODE_RUN: begin
					rc_set = `RCM_TO; // see [R6]
				end
				`MODE_IDLE, `MODE_SLEEP: begin
					rc_set = `RCM_TO; // see [R6]
					rc_clr = `RCM_PD;
				end
				default: begin
					rc_set = 8'h00;
				end
			endcase
		end else if (watchdog_evt) begin
			if (low_power) begin
				cat = `CAT_WAKE_WDT;
				rc_clr = `RCM_TO | `RCM_PD; // see [R8]
			end else begin
				cat = `CAT_RESET;
				rc_clr = `RCM_TO; // see [R7]
			end
		end else if (reset_instr_evt) begin
			cat = `CAT_RESET;
			rc_clr = `RCM_RI; // see [R5]
		end else if (stack_full_evt) begin
			stk_set = `STK_FULL_MASK; // see [R9]
			cat = stack_overflow_reset_enable ? `CAT_RESET : `CAT_FLAG;
		end else if (stack_underflow_evt) begin
			stk_set = `STK_UNF_MASK; // see [R9] [R10]
			cat = stack_overflow_reset_enable ? `CAT_RESET : `CAT_FLAG;
		end else if (int_wake_evt) begin
			cat = `CAT_WAKE_INT;
			rc_clr = `RCM_PD; // see [R11]
		end
	end

endmodule

//--- reset_init_defs.vh
`ifndef RESET_INIT_DEFS_VH
`define RESET_INIT_DEFS_VH

// Register indices on the register port.
`define IDX_RESET_STATUS  5'h00
`define IDX_STACK_INDEX   5'h01
`define IDX_RET_UPPER     5'h02
`define IDX_RET_HIGH      5'h03
`define IDX_RET_LOW       5'h04
`define IDX_PCLATCH_UPPER 5'h05
`define IDX_PCLATCH_HIGH  5'h06
`define IDX_PC_LOW        5'h07
`define IDX_TBL_UPPER     5'h08
`define IDX_TBL_HIGH      5'h09
`define IDX_TBL_LOW       5'h0A
`define IDX_TBL_LATCH     5'h0B
`define IDX_PROD_HIGH     5'h0C
`define IDX_PROD_LOW      5'h0D
`define IDX_INT_CTRL_A    5'h0E
`define IDX_INT_CTRL_B    5'h0F
`define IDX_INT_CTRL_C    5'h10
`define IDX_IND0_HIGH     5'h11
`define IDX_IND0_LOW      5'h12
`define IDX_IND1_HIGH     5'h13
`define IDX_IND1_LOW      5'h14
`define IDX_WORKING       5'h15
`define IDX_BANK_SELECT   5'h16
`define IDX_EVT_STATUS    5'h17
`define IDX_EVT_MASK      5'h18
`define NUM_CORE          5'h17

// Reset control and status bit masks.
`define RCM_SBO 8'h40
`define RCM_RI  8'h10
`define RCM_TO  8'h08
`define RCM_PD  8'h04
`define RCM_POR 8'h02
`define RCM_BOR 8'h01
`define RESET_CONTROL_STATUS_SW_MASK 8'h43
`define RESET_CONTROL_STATUS_POR_VAL 8'h5C

// Stack index fields.
`define STK_FULL_MASK 8'h80
`define STK_UNF_MASK  8'h40
`define STK_PTR_MASK  8'h1F
`define STK_RD_MASK   8'hDF

// Implemented-bit masks of narrow registers.
`define MASK_5BIT 8'h1F
`define MASK_6BIT 8'h3F
`define MASK_4BIT 8'h0F

// Interrupt control reset values and enable bits.
`define INTA_RST_MASK 8'h01
`define INTB_RST_VAL  8'hFF
`define INTC_RST_VAL  8'hC0
`define GIE_HIGH_BIT  7
`define GIE_LOW_BIT   6

// Event categories.
`define CAT_NONE     3'h0
`define CAT_BOR      3'h1
`define CAT_RESET    3'h2
`define CAT_WAKE_WDT 3'h3
`define CAT_WAKE_INT 3'h4
`define CAT_FLAG     3'h5

// Power modes.
`define MODE_FULL  2'h0
`define MODE_RUN   2'h1
`define MODE_IDLE  2'h2
`define MODE_SLEEP 2'h3

// Brown-out configurations.
`define BOR_CFG_OFF 2'h0
`define BOR_CFG_SW  2'h1
`define BOR_CFG_HW_NOSLEEP 2'h2

// Program counter values.
`define RESET_PC 21'h000000
`define VEC_HIGH 21'h000008
`define VEC_LOW  21'h000018
`define PC_STEP  21'h000002

`endif

//--- reset_init_props.sv
`timescale 1ns/1ps
`include "reset_init_defs.vh"

module reset_init_props (
	// Clock and reset.
	input wire        core_clk,
	input wire        resetn,
	// Event pulses.
	input wire        brownout_evt,
	input wire        external_reset_pin_evt,
	input wire        watchdog_evt,
	input wire        reset_instr_evt,
	input wire        stack_full_evt,
	input wire        stack_underflow_evt,
	input wire        int_wake_evt,
	// Conditions.
	input wire [1:0]  power_mode,
	input wire        stack_overflow_reset_enable,
	input wire [1:0]  brownout_config,
	input wire [20:0] current_pc,
	// Core control outputs.
	input wire [20:0] program_counter_r,
	input wire        pc_load_r,
	input wire        brownout_active_r
);
	default clocking cb @(posedge core_clk); endclocking

	// Event groupings by priority, used by several properties.
	wire hi = brownout_evt | external_reset_pin_evt;
	wire mid = hi | watchdog_evt | reset_instr_evt;
	wire any_evt = mid | stack_full_evt | stack_underflow_evt | int_wake_evt;
	wire stk_any = stack_full_evt | stack_underflow_evt;
	wire int_alone = int_wake_evt && !mid && !stk_any &&
		power_mode != `MODE_FULL;

	property p_bor_pc;
		disable iff (!resetn) brownout_evt ||
			(reset_instr_evt && !hi && !watchdog_evt) |=>
			program_counter_r == `RESET_PC && pc_load_r;
	endproperty
	property p_pin_pc;
		disable iff (!resetn) external_reset_pin_evt |=>
			program_counter_r == `RESET_PC && pc_load_r;
	endproperty
	property p_wdt_run;
		disable iff (!resetn) watchdog_evt && !hi && !power_mode[1] |=>
			program_counter_r == `RESET_PC && pc_load_r;
	endproperty
	property p_wdt_sleep;
		disable iff (!resetn) watchdog_evt && !hi && power_mode[1] |=>
			program_counter_r == $past(current_pc) + `PC_STEP;
	endproperty
	property p_stk_rst;
		disable iff (!resetn) !mid && stk_any && stack_overflow_reset_enable
			|=> program_counter_r == `RESET_PC && pc_load_r;
	endproperty
	property p_unf_norst;
		disable iff (!resetn) stack_underflow_evt && !stack_full_evt &&
			!mid && !int_wake_evt && !stack_overflow_reset_enable |=> !pc_load_r;
	endproperty
	property p_idle;
		disable iff (!resetn) !any_evt |=>
			!pc_load_r && $stable(program_counter_r);
	endproperty
	property p_int_wake;
		disable iff (!resetn) int_alone ##1 !any_evt |->
			pc_load_r && (program_counter_r == `VEC_HIGH ||
			program_counter_r == `VEC_LOW ||
			program_counter_r == $past(current_pc) + `PC_STEP) ##1 !pc_load_r;
	endproperty
	property p_bor_act;
		disable iff (!resetn) brownout_config != `BOR_CFG_SW &&
			brownout_config != `BOR_CFG_HW_NOSLEEP |=>
			brownout_active_r == $past(brownout_config[1]);
	endproperty

	// Each property checked once, with a one-line message on failure.
	a_bor_pc: assert property (p_bor_pc)
		else $error("pc not restarted on brown-out or instruction");
	a_pin_pc: assert property (p_pin_pc)
		else $error("pc not restarted on pin reset");
	a_wdt_run: assert property (p_wdt_run)
		else $error("pc not restarted on running watchdog");
	a_wdt_sleep: assert property (p_wdt_sleep)
		else $error("pc not advanced on sleeping watchdog");
	a_stk_rst: assert property (p_stk_rst)
		else $error("pc not restarted on stack reset");
	a_unf_norst: assert property (p_unf_norst)
		else $error("disabled underflow caused a reset");
	a_idle: assert property (p_idle)
		else $error("pc moved without an event");
	a_int_wake: assert property (p_int_wake)
		else $error("interrupt wake pc wrong");
	a_bor_act: assert property (p_bor_act)
		else $error("brown-out enable does not follow config");

	// Main scenarios reached.
	c_wdt_sleep: cover property (watchdog_evt && power_mode[1]);
	c_int_wake: cover property (int_alone);
	c_stk_full: cover property (stack_full_evt && !mid);
endmodule

bind reset_cause_and_register_init reset_init_props i_props (
	.core_clk(core_clk), .resetn(resetn), .brownout_evt(brownout_evt),
	.external_reset_pin_evt(external_reset_pin_evt),
	.watchdog_evt(watchdog_evt), .reset_instr_evt(reset_instr_evt),
	.stack_full_evt(stack_full_evt), .int_wake_evt(int_wake_evt),
	.stack_underflow_evt(stack_underflow_evt), .power_mode(power_mode),
	.stack_overflow_reset_enable(stack_overflow_reset_enable),
	.brownout_config(brownout_config), .current_pc(current_pc),
	.program_counter_r(program_counter_r), .pc_load_r(pc_load_r),
	.brownout_active_r(brownout_active_r)
);

//--- test_reset_cause_and_register_init.sv
`timescale 1ns/1ps
`include "reset_init_defs.vh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
	error_cnt++; $display("Error %s expected %0h seen %0h", n, e, g); end end

module test_reset_cause_and_register_init;
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [6:0]  ev_v = 7'h00;
	logic [1:0]  power_mode = 2'h0;
	logic        stack_overflow_reset_enable = 1'b0;
	logic [1:0]  brownout_config = 2'h1;
	logic [20:0] current_pc = 21'h0;
	logic [7:0]  wake_flags = 8'h00;
	logic [4:0]  reg_addr = 5'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	wire  [7:0]  reg_rdata_r;
	wire  [20:0] program_counter_r;
	wire         pc_load_r;
	wire         brownout_active_r;
	wire         irq_r;
	integer      error_cnt = 0;
	integer      n_checks = 0;
	integer      seed = 37648;

	// 40 MHz core clock.
	always #12.5 core_clk = ~core_clk;

	reset_cause_and_register_init i_dut (
		.core_clk(core_clk), .resetn(resetn), .brownout_evt(ev_v[0]),
		.external_reset_pin_evt(ev_v[1]), .watchdog_evt(ev_v[2]),
		.reset_instr_evt(ev_v[3]), .stack_full_evt(ev_v[4]),
		.stack_underflow_evt(ev_v[5]), .int_wake_evt(ev_v[6]),
		.power_mode(power_mode), .brownout_config(brownout_config),
		.stack_overflow_reset_enable(stack_overflow_reset_enable),
		.current_pc(current_pc), .wake_flags(wake_flags),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
		.program_counter_r(program_counter_r), .pc_load_r(pc_load_r),
		.brownout_active_r(brownout_active_r), .irq_r(irq_r)
	);

	// Verdict and end of run.
	task test_done;
		if (error_cnt == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Register port cycles; read data is compared in the cycle it stands.
	task wr(input [4:0] a, input [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [4:0] a, input [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		`CHK($sformatf("reg %0h", a), e, reg_rdata_r)
	endtask
	task wrnd(input [4:0] a, input [7:0] msk, output [7:0] v);
		v = $random(seed) & msk;
		wr(a, v);
	endtask

	// One event pulse with its conditions, ending where results stand.
	task ev(input [2:0] k, input [1:0] m, input en, input [20:0] p,
		input [7:0] w);
		@(posedge core_clk);
		ev_v <= 7'h01 << k;
		power_mode <= m;
		stack_overflow_reset_enable <= en;
		current_pc <= p;
		wake_flags <= w;
		@(posedge core_clk);
		ev_v <= 7'h00;
		@(negedge core_clk);
	endtask

	// Power-on reset held for 6 cycles under a brown-out configuration.
	task por(input [1:0] cfg);
		@(posedge core_clk);
		resetn <= 1'b0;
		brownout_config <= cfg;
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
	endtask

	// Expected reset status after one event from status r in mode m.
	function [7:0] f_rc(input [7:0] r, input [2:0] k, input [1:0] m);
		case (k)
		3'h0: f_rc = (r | 8'h1C) & 8'hFE;
		3'h1: f_rc = m == 2'h1 ? r | 8'h08 :
			m[1] ? (r | 8'h08) & 8'hFB : r;
		3'h2: f_rc = m[1] ? r & 8'hF3 : r & 8'hF7;
		3'h3: f_rc = r & 8'hEF;
		3'h6: f_rc = r & 8'hFB;
		default: f_rc = r;
		endcase
	endfunction

	// Watchdog on the whole run.
	initial begin
		#400000;
		error_cnt++;
		test_done();
	end

	// Main sequence.
	initial begin
		logic [7:0]  rc, stk, d, tl, wk, bk, ia, ib, mk, wf;
		logic [20:0] pc, p2, epc;
		logic [2:0]  k;
		logic [1:0]  m;
		logic        en, rst, wake, vec;
		por(2'h1);
		rd(`IDX_RESET_STATUS, `RESET_CONTROL_STATUS_POR_VAL);
		rd(`IDX_STACK_INDEX, 8'h00);
		rd(`IDX_INT_CTRL_A, 8'h00);
		rd(`IDX_INT_CTRL_B, `INTB_RST_VAL);
		rd(`IDX_INT_CTRL_C, `INTC_RST_VAL);
		rd(`IDX_TBL_LATCH, 8'h00);
		rd(`IDX_BANK_SELECT, 8'h00);
		`CHK("pc", `RESET_PC, program_counter_r)
		wr(5'h19, 8'hA5);
		rd(5'h19, 8'h00);
		rc = `RESET_CONTROL_STATUS_POR_VAL;
		stk = 8'h00;
		for (int i = 0; i < 56; i++) begin
			k = i % 7;
			m = (i / 7) % 4;
			if (k == 3'h6 && m == 2'h0)
				m = 2'h3;
			en = $random(seed);
			pc = $random(seed);
			p2 = pc + `PC_STEP;
			wrnd(`IDX_RESET_STATUS, `RESET_CONTROL_STATUS_SW_MASK, d);
			rc = (rc & ~`RESET_CONTROL_STATUS_SW_MASK) | d;
			wrnd(`IDX_WORKING, 8'hFF, wk);
			wrnd(`IDX_BANK_SELECT, `MASK_4BIT, bk);
			wrnd(`IDX_TBL_LATCH, 8'hFF, tl);
			wrnd(`IDX_INT_CTRL_A, 8'hFF, ia);
			wrnd(`IDX_INT_CTRL_B, 8'hFF, ib);
			wrnd(`IDX_EVT_MASK, 8'h7F, mk);
			wf = $random(seed) & 8'h3E;
			rst = (k < 3'h4 && !(k == 3'h2 && m[1])) ||
				(k[2] && !k[1] && en);
			wake = (k == 3'h2 && m[1]) || k == 3'h6;
			vec = k == 3'h6 && (ia[`GIE_HIGH_BIT] || ia[`GIE_LOW_BIT]);
			epc = rst ? `RESET_PC : !vec ? p2 :
				ia[`GIE_HIGH_BIT] ? `VEC_HIGH : `VEC_LOW;
			ev(k, m, en, pc, wf);
			`CHK("load", rst | wake, pc_load_r)
			`CHK("irq", mk[k], irq_r)
			if (rst | wake)
				`CHK("pc", epc, program_counter_r)
			rc = f_rc(rc, k, m);
			if (k == 3'h4)
				stk = stk | `STK_FULL_MASK;
			if (k == 3'h5)
				stk = stk | `STK_UNF_MASK;
			if (rst)
				stk = stk & 8'hC0;
			if (vec)
				stk = stk + 8'h01;
			rd(`IDX_RESET_STATUS, rc);
			rd(`IDX_STACK_INDEX, stk & `STK_RD_MASK);
			if (k != 3'h0)
				rd(`IDX_WORKING, wk);
			rd(`IDX_BANK_SELECT, rst ? 8'h00 : bk);
			rd(`IDX_TBL_LATCH, rst ? 8'h00 : tl);
			if (k != 3'h0)
				rd(`IDX_INT_CTRL_A, rst ? ia & `INTA_RST_MASK :
					k == 3'h6 ? ia | wf : ia);
			rd(`IDX_INT_CTRL_B, rst ? `INTB_RST_VAL : ib);
			if (rst || (wake && !vec))
				rd(`IDX_PC_LOW, rst ? 8'h00 : p2[7:0]);
			if (rst || vec)
				rd(`IDX_RET_LOW, rst ? 8'h00 : p2[7:0]);
			rd(`IDX_EVT_STATUS, 8'h01 << k);
			wr(`IDX_EVT_STATUS, 8'hFF);
			rd(`IDX_EVT_STATUS, 8'h00);
			`CHK("irq", 1'b0, irq_r)
		end
		for (int c = 0; c < 4; c++) begin
			wr(`IDX_RESET_STATUS, `RCM_SBO);
			por(c);
			rd(`IDX_RESET_STATUS, c == 1 ? `RESET_CONTROL_STATUS_POR_VAL : 8'h1C);
			`CHK("bor act", c == 0 ? 1'b0 : c == 2 ? power_mode != 2'h3 : 1'b1, brownout_active_r)
		end
		test_done();
	end
endmodule
